// ==== logic/ppr_pin_route.sv ====
// peripheral pin route selector top
`timescale 1ns/1ps
module ppr_pin_route (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ppr_pkg::ADDR_W-1:0] paddr,
  input  wire logic [ppr_pkg::DATA_W-1:0] pwdata,
  output logic      [ppr_pkg::DATA_W-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [ppr_pkg::NSRC-1:0]  periph_val,
  input  wire logic [ppr_pkg::NSRC-1:0]  periph_en,
  output logic      [ppr_pkg::NIN-1:0]   periph_in,
  input  wire logic [7:0]                pin_a_in,
  input  wire logic [7:0]                pin_c_in,
  input  wire logic [7:0]                pin_d_in,
  input  wire logic [7:0]                pin_f_in,
  output logic      [7:0]                pin_a_out,
  output logic      [7:0]                pin_c_out,
  output logic      [7:0]                pin_d_out,
  output logic      [7:0]                pin_f_out,
  output logic      [7:0]                pin_a_oe_n,
  output logic      [7:0]                pin_c_oe_n,
  output logic      [7:0]                pin_d_oe_n,
  output logic      [7:0]                pin_f_oe_n
);
  // serial zero: sig 0 tx, 1 rx, 2 clock, 3 direction
  function automatic ppr_pkg::ppr_pin_t sp0_pin(logic [2:0] c,
                                                logic [1:0] s);
    logic [2:0] b;
    b = {1'b0, s};
    case (c)
      ppr_pkg::SP0_DEFAULT: return ppr_pkg::pin(ppr_pkg::PORT_A, b);
      ppr_pkg::SP0_ALT1:    return ppr_pkg::pin(ppr_pkg::PORT_A, b + 3'h4);
      ppr_pkg::SP0_ALT2:    return (s < 2'h2) ?
                              ppr_pkg::pin(ppr_pkg::PORT_A, b + 3'h2) :
                              ppr_pkg::NOPIN;
      ppr_pkg::SP0_ALT3:    return ppr_pkg::pin(ppr_pkg::PORT_D, b + 3'h4);
      ppr_pkg::SP0_ALT4:    return (s < 2'h3) ?
                              ppr_pkg::pin(ppr_pkg::PORT_C, b + 3'h1) :
                              ppr_pkg::NOPIN;
      default:              return ppr_pkg::NOPIN;
    endcase
  endfunction

  // serial one
  function automatic ppr_pkg::ppr_pin_t sp1_pin(logic [1:0] c,
                                                logic [1:0] s);
    logic [2:0] b;
    b = {1'b0, s};
    case (c)
      ppr_pkg::SP1_DEFAULT: return ppr_pkg::pin(ppr_pkg::PORT_C, b);
      ppr_pkg::SP1_ALT2:    return (s < 2'h2) ?
                              ppr_pkg::pin(ppr_pkg::PORT_D, b + 3'h6) :
                              ppr_pkg::NOPIN;
      default:              return ppr_pkg::NOPIN;
    endcase
  endfunction

  // spi: sig 0 mosi, 1 miso, 2 sck, 3 ss
  function automatic ppr_pkg::ppr_pin_t spi_pin(logic [2:0] c,
                                                logic [1:0] s);
    logic [2:0] b;
    b = {1'b0, s};
    case (c)
      ppr_pkg::SPI_DEFAULT: return ppr_pkg::pin(ppr_pkg::PORT_A, b + 3'h4);
      ppr_pkg::SPI_ALT3:    return (s < 2'h2) ?
                              ppr_pkg::pin(ppr_pkg::PORT_A, b) :
                              ppr_pkg::pin(ppr_pkg::PORT_C, b - 3'h2);
      ppr_pkg::SPI_ALT4:    return ppr_pkg::pin(ppr_pkg::PORT_D, b + 3'h4);
      ppr_pkg::SPI_ALT5:    return ppr_pkg::pin(ppr_pkg::PORT_C, b);
      ppr_pkg::SPI_ALT6:    return (s < 2'h3) ?
                              ppr_pkg::pin(ppr_pkg::PORT_C, b + 3'h1) :
                              ppr_pkg::pin(ppr_pkg::PORT_F, 3'h7);
      default:              return ppr_pkg::NOPIN;
    endcase
  endfunction

  // two-wire: sig 0 sda, 1 scl, 2 dual sda, 3 dual scl
  function automatic ppr_pkg::ppr_pin_t tw_pin(logic [1:0] c,
                                               logic [1:0] s);
    logic [2:0] b;
    logic       dual;
    b = {1'b0, s};
    dual = s[1];
    case (c)
      ppr_pkg::TW_DEFAULT: return dual ? ppr_pkg::pin(ppr_pkg::PORT_C, b) :
                             ppr_pkg::pin(ppr_pkg::PORT_A, b + 3'h2);
      ppr_pkg::TW_ALT1:    return dual ? ppr_pkg::NOPIN :
                             ppr_pkg::pin(ppr_pkg::PORT_A, b + 3'h2);
      ppr_pkg::TW_ALT2:    return dual ? ppr_pkg::NOPIN :
                             ppr_pkg::pin(ppr_pkg::PORT_C, b + 3'h2);
      ppr_pkg::TW_ALT3:    return dual ? ppr_pkg::pin(ppr_pkg::PORT_C, b) :
                             ppr_pkg::pin(ppr_pkg::PORT_A, b);
      default:             return ppr_pkg::NOPIN;
    endcase
  endfunction

  // timer a waveform output n
  function automatic ppr_pkg::ppr_pin_t ta_pin(logic [2:0] c,
                                               logic [2:0] n);
    case (c)
      ppr_pkg::TA_PORTA: return ppr_pkg::pin(ppr_pkg::PORT_A, n);
      ppr_pkg::TA_PORTC: return (n < 3'h4) ?
                           ppr_pkg::pin(ppr_pkg::PORT_C, n) : ppr_pkg::NOPIN;
      ppr_pkg::TA_PORTD: return (n != 3'h0) ?
                           ppr_pkg::pin(ppr_pkg::PORT_D, n) : ppr_pkg::NOPIN;
      ppr_pkg::TA_PORTF: return ppr_pkg::pin(ppr_pkg::PORT_F, n);
      default:           return ppr_pkg::NOPIN;
    endcase
  endfunction

  // pwm timer waveform output n (a to d)
  function automatic ppr_pkg::ppr_pin_t pw_pin(logic [2:0] c,
                                               logic [1:0] n);
    logic [2:0] b;
    b = {1'b0, n};
    case (c)
      ppr_pkg::PW_DEFAULT: return ppr_pkg::pin(ppr_pkg::PORT_A, b + 3'h4);
      ppr_pkg::PW_ALT2:    return ppr_pkg::pin(ppr_pkg::PORT_F, b);
      ppr_pkg::PW_ALT4:    return (n < 2'h2) ?
                             ppr_pkg::pin(ppr_pkg::PORT_A, b + 3'h4) :
                             ppr_pkg::pin(ppr_pkg::PORT_D, b + 3'h2);
      default:             return ppr_pkg::NOPIN;
    endcase
  endfunction

  // reset release
  logic rst_s1_reg;
  logic rst_s2_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire rst_n_sync = rst_s2_reg;

  logic [7:0] event_route;
  logic [7:0] logic_route;
  logic [7:0] serial_route;
  logic [7:0] spi_route;
  logic [7:0] two_wire_route;
  logic [7:0] timer_a_route;
  logic [7:0] timer_b_route;
  logic [7:0] pwm_route;
  logic [7:0] status;

  ppr_reg_bank u_regs (
    .clk            (clk),
    .rst_n          (rst_n_sync),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .status         (status),
    .event_route    (event_route),
    .logic_route    (logic_route),
    .serial_route   (serial_route),
    .spi_route      (spi_route),
    .two_wire_route (two_wire_route),
    .timer_a_route  (timer_a_route),
    .timer_b_route  (timer_b_route),
    .pwm_route      (pwm_route)
  );

  wire [2:0] sp0_code = serial_route[ppr_pkg::SP0_LSB +: 3];
  wire [1:0] sp1_code = serial_route[ppr_pkg::SP1_LSB +: 2];
  wire [2:0] spi_code = spi_route[2:0];
  wire [1:0] tw_code  = two_wire_route[1:0];
  wire [2:0] ta_code  = timer_a_route[2:0];
  wire [2:0] pw_code  = pwm_route[2:0];

  // pin selection per peripheral output slot
  ppr_pkg::ppr_pin_t src_pin [ppr_pkg::NSRC];
  ppr_pkg::ppr_pin_t in_pin  [ppr_pkg::NIN];

  assign src_pin[ppr_pkg::S_EV] = event_route[ppr_pkg::EV_A_POS] ?
    ppr_pkg::pin(ppr_pkg::PORT_A, 3'h7) :
    ppr_pkg::pin(ppr_pkg::PORT_A, 3'h2);
  assign src_pin[ppr_pkg::S_EV+1] = event_route[ppr_pkg::EV_D_POS] ?
    ppr_pkg::pin(ppr_pkg::PORT_D, 3'h7) :
    ppr_pkg::pin(ppr_pkg::PORT_D, 3'h2);
  assign src_pin[ppr_pkg::S_EV+2] = event_route[ppr_pkg::EV_F_POS] ?
    ppr_pkg::pin(ppr_pkg::PORT_F, 3'h7) :
    ppr_pkg::pin(ppr_pkg::PORT_F, 3'h2);
  assign src_pin[ppr_pkg::S_LUT] = logic_route[ppr_pkg::LT0_POS] ?
    ppr_pkg::pin(ppr_pkg::PORT_A, 3'h6) :
    ppr_pkg::pin(ppr_pkg::PORT_A, 3'h3);
  assign src_pin[ppr_pkg::S_LUT+1] = logic_route[ppr_pkg::LT1_POS] ?
    ppr_pkg::NOPIN :
    ppr_pkg::pin(ppr_pkg::PORT_C, 3'h3);
  assign src_pin[ppr_pkg::S_LUT+2] = logic_route[ppr_pkg::LT2_POS] ?
    ppr_pkg::pin(ppr_pkg::PORT_D, 3'h6) :
    ppr_pkg::pin(ppr_pkg::PORT_D, 3'h3);
  assign src_pin[ppr_pkg::S_TB] = timer_b_route[ppr_pkg::TB0_POS] ?
    ppr_pkg::pin(ppr_pkg::PORT_F, 3'h4) :
    ppr_pkg::pin(ppr_pkg::PORT_A, 3'h2);
  assign src_pin[ppr_pkg::S_TB+1] = timer_b_route[ppr_pkg::TB1_POS] ?
    ppr_pkg::pin(ppr_pkg::PORT_F, 3'h5) :
    ppr_pkg::pin(ppr_pkg::PORT_A, 3'h3);

  // table inputs stay put whatever the route bit
  for (genvar i = 0; i < 3; i++) begin : g_lut_in
    assign in_pin[ppr_pkg::I_LT0+i] =
      ppr_pkg::pin(ppr_pkg::PORT_A, 3'(i));
    assign in_pin[ppr_pkg::I_LT1+i] =
      ppr_pkg::pin(ppr_pkg::PORT_C, 3'(i));
  end
  for (genvar i = 0; i < 2; i++) begin : g_lt2_in
    assign in_pin[ppr_pkg::I_LT2+i] =
      ppr_pkg::pin(ppr_pkg::PORT_D, 3'(i + 1));
  end

  for (genvar s = 0; s < 4; s++) begin : g_four
    assign src_pin[ppr_pkg::S_SP0+s] = sp0_pin(sp0_code, 2'(s));
    assign src_pin[ppr_pkg::S_SP1+s] = sp1_pin(sp1_code, 2'(s));
    assign src_pin[ppr_pkg::S_SPI+s] = spi_pin(spi_code, 2'(s));
    assign src_pin[ppr_pkg::S_TW+s]  = tw_pin(tw_code, 2'(s));
    assign src_pin[ppr_pkg::S_PW+s]  = pw_pin(pw_code, 2'(s));
    assign in_pin[ppr_pkg::I_SPI+s]  = spi_pin(spi_code, 2'(s));
    assign in_pin[ppr_pkg::I_TW+s]   = tw_pin(tw_code, 2'(s));
  end
  for (genvar s = 0; s < 2; s++) begin : g_serial_in
    assign in_pin[ppr_pkg::I_SP0+s] = sp0_pin(sp0_code, 2'(s + 1));
    assign in_pin[ppr_pkg::I_SP1+s] = sp1_pin(sp1_code, 2'(s + 1));
  end
  for (genvar n = 0; n < 6; n++) begin : g_timer_a
    assign src_pin[ppr_pkg::S_TA+n] = ta_pin(ta_code, 3'(n));
  end

  // serial, spi, timer a and pwm groups left on no pin, reported in status
  wire sp0_off = !src_pin[ppr_pkg::S_SP0][5];
  wire sp1_off = !src_pin[ppr_pkg::S_SP1][5];
  wire spi_off = !src_pin[ppr_pkg::S_SPI][5];
  wire ta_off  = !src_pin[ppr_pkg::S_TA+1][5];
  wire pw_off  = !src_pin[ppr_pkg::S_PW][5];
  logic clash;
  assign status = {2'h0, clash, pw_off, ta_off, spi_off, sp1_off, sp0_off};

  // pin input synchronisers
  logic [31:0] pin_s1_reg;
  logic [31:0] pin_s2_reg;
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else begin
      pin_s1_reg <= {pin_f_in, pin_d_in, pin_c_in, pin_a_in};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // pin drive merge; lower slot wins a shared pin
  logic [31:0] drv_next;
  logic [31:0] val_next;
  always_comb begin
    drv_next = '0;
    val_next = '0;
    clash    = 1'b0;
    for (int s = ppr_pkg::NSRC - 1; s >= 0; s--) begin
      if (src_pin[s][5] && periph_en[s]) begin
        if (drv_next[src_pin[s][4:0]]) begin
          clash = 1'b1;
        end
        drv_next[src_pin[s][4:0]] = 1'b1;
        val_next[src_pin[s][4:0]] = periph_val[s];
      end
    end
  end

  logic [ppr_pkg::NIN-1:0] in_next;
  for (genvar i = 0; i < ppr_pkg::NIN; i++) begin : g_in
    assign in_next[i] = in_pin[i][5] ? pin_s2_reg[in_pin[i][4:0]] :
                        ppr_pkg::IN_IDLE[i];
  end

  logic [31:0]             pin_out_reg;
  logic [31:0]             pin_oe_n_reg;
  logic [ppr_pkg::NIN-1:0] periph_in_reg;
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      pin_out_reg   <= '0;
      pin_oe_n_reg  <= '1;
      periph_in_reg <= ppr_pkg::IN_IDLE;
    end else begin
      pin_out_reg   <= val_next;
      pin_oe_n_reg  <= ~drv_next;
      periph_in_reg <= in_next;
    end
  end

  assign periph_in  = periph_in_reg;
  assign pin_a_out  = pin_out_reg[7:0];
  assign pin_c_out  = pin_out_reg[15:8];
  assign pin_d_out  = pin_out_reg[23:16];
  assign pin_f_out  = pin_out_reg[31:24];
  assign pin_a_oe_n = pin_oe_n_reg[7:0];
  assign pin_c_oe_n = pin_oe_n_reg[15:8];
  assign pin_d_oe_n = pin_oe_n_reg[23:16];
  assign pin_f_oe_n = pin_oe_n_reg[31:24];
endmodule // ppr_pin_route

// ==== shared/ppr_pkg.sv ====
// constants and pin helpers for the peripheral pin route selector
package ppr_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NREG   = 16;
  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_EVENT   = 4'h0;
  localparam logic [3:0] IDX_LOGIC   = 4'h1;
  localparam logic [3:0] IDX_SERIAL  = 4'h2;
  localparam logic [3:0] IDX_SPI     = 4'h5;
  localparam logic [3:0] IDX_TWOWIRE = 4'h6;
  localparam logic [3:0] IDX_TIMER_A = 4'h7;
  localparam logic [3:0] IDX_TIMER_B = 4'h8;
  localparam logic [3:0] IDX_PWM     = 4'h9;
  localparam logic [3:0] IDX_STATUS  = 4'ha;
  // writable bits per register
  localparam logic [7:0] MASK_EVENT   = 8'h29;
  localparam logic [7:0] MASK_LOGIC   = 8'h07;
  localparam logic [7:0] MASK_SERIAL  = 8'h1f;
  localparam logic [7:0] MASK_SPI     = 8'h07;
  localparam logic [7:0] MASK_TWOWIRE = 8'h03;
  localparam logic [7:0] MASK_TIMER_A = 8'h07;
  localparam logic [7:0] MASK_TIMER_B = 8'h03;
  localparam logic [7:0] MASK_PWM     = 8'h07;
  localparam logic [7:0] RST_ROUTE    = 8'h00;
  // field positions
  localparam int EV_F_POS = 5;
  localparam int EV_D_POS = 3;
  localparam int EV_A_POS = 0;
  localparam int LT2_POS  = 2;
  localparam int LT1_POS  = 1;
  localparam int LT0_POS  = 0;
  localparam int SP1_LSB  = 3;
  localparam int SP0_LSB  = 0;
  localparam int TB1_POS  = 1;
  localparam int TB0_POS  = 0;
  localparam int ST_CLASH = 5;
  // route codes
  localparam logic [2:0] SP0_DEFAULT = 3'h0;
  localparam logic [2:0] SP0_ALT1    = 3'h1;
  localparam logic [2:0] SP0_ALT2    = 3'h2;
  localparam logic [2:0] SP0_ALT3    = 3'h3;
  localparam logic [2:0] SP0_ALT4    = 3'h4;
  localparam logic [1:0] SP1_DEFAULT = 2'h0;
  localparam logic [1:0] SP1_ALT2    = 2'h2;
  localparam logic [2:0] SPI_DEFAULT = 3'h0;
  localparam logic [2:0] SPI_ALT3    = 3'h3;
  localparam logic [2:0] SPI_ALT4    = 3'h4;
  localparam logic [2:0] SPI_ALT5    = 3'h5;
  localparam logic [2:0] SPI_ALT6    = 3'h6;
  localparam logic [1:0] TW_DEFAULT  = 2'h0;
  localparam logic [1:0] TW_ALT1     = 2'h1;
  localparam logic [1:0] TW_ALT2     = 2'h2;
  localparam logic [1:0] TW_ALT3     = 2'h3;
  localparam logic [2:0] TA_PORTA    = 3'h0;
  localparam logic [2:0] TA_PORTC    = 3'h2;
  localparam logic [2:0] TA_PORTD    = 3'h3;
  localparam logic [2:0] TA_PORTF    = 3'h5;
  localparam logic [2:0] PW_DEFAULT  = 3'h0;
  localparam logic [2:0] PW_ALT2     = 3'h2;
  localparam logic [2:0] PW_ALT4     = 3'h4;
  // pin ports
  localparam logic [1:0] PORT_A = 2'h0;
  localparam logic [1:0] PORT_C = 2'h1;
  localparam logic [1:0] PORT_D = 2'h2;
  localparam logic [1:0] PORT_F = 2'h3;
  // peripheral output slots
  localparam int S_EV   = 0;
  localparam int S_LUT  = 3;
  localparam int S_SP0  = 6;
  localparam int S_SP1  = 10;
  localparam int S_SPI  = 14;
  localparam int S_TW   = 18;
  localparam int S_TA   = 22;
  localparam int S_TB   = 28;
  localparam int S_PW   = 30;
  localparam int NSRC   = 34;
  // peripheral input slots
  localparam int I_LT0  = 0;
  localparam int I_LT1  = 3;
  localparam int I_LT2  = 6;
  localparam int I_SP0  = 8;
  localparam int I_SP1  = 10;
  localparam int I_SPI  = 12;
  localparam int I_TW   = 16;
  localparam int NIN    = 20;
  localparam logic [NIN-1:0] IN_IDLE = 20'hfc500;
  // pin id: valid, port, bit
  typedef logic [5:0] ppr_pin_t;
  localparam ppr_pin_t NOPIN = 6'h00;
  function automatic ppr_pin_t pin(logic [1:0] p, logic [2:0] b);
    return {1'b1, p, b};
  endfunction
endpackage

// ==== logic/ppr_reg_bank.sv ====
// apb register bank for the route selector
`timescale 1ns/1ps
module ppr_reg_bank (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ppr_pkg::ADDR_W-1:0] paddr,
  input  wire logic [ppr_pkg::DATA_W-1:0] pwdata,
  output logic      [ppr_pkg::DATA_W-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [7:0]                status,
  output logic      [7:0]                event_route,
  output logic      [7:0]                logic_route,
  output logic      [7:0]                serial_route,
  output logic      [7:0]                spi_route,
  output logic      [7:0]                two_wire_route,
  output logic      [7:0]                timer_a_route,
  output logic      [7:0]                timer_b_route,
  output logic      [7:0]                pwm_route
);
  function automatic logic [7:0] wmask(logic [3:0] i);
    case (i)
      ppr_pkg::IDX_EVENT:   return ppr_pkg::MASK_EVENT;
      ppr_pkg::IDX_LOGIC:   return ppr_pkg::MASK_LOGIC;
      ppr_pkg::IDX_SERIAL:  return ppr_pkg::MASK_SERIAL;
      ppr_pkg::IDX_SPI:     return ppr_pkg::MASK_SPI;
      ppr_pkg::IDX_TWOWIRE: return ppr_pkg::MASK_TWOWIRE;
      ppr_pkg::IDX_TIMER_A: return ppr_pkg::MASK_TIMER_A;
      ppr_pkg::IDX_TIMER_B: return ppr_pkg::MASK_TIMER_B;
      ppr_pkg::IDX_PWM:     return ppr_pkg::MASK_PWM;
      default:              return 8'h00;
    endcase
  endfunction

  logic [7:0]  route_reg [ppr_pkg::NREG];
  logic [ppr_pkg::DATA_W-1:0] prdata_reg;
  wire  [3:0]  idx     = paddr[5:2];
  wire         aligned = (paddr[1:0] == 2'h0) &&
                         (paddr[ppr_pkg::ADDR_W-1:6] == '0);
  wire         is_stat = (idx == ppr_pkg::IDX_STATUS);
  wire         hit     = aligned && ((wmask(idx) != 8'h00) || is_stat);
  wire         access  = psel && penable;
  wire         wr_en   = access && pwrite && hit;
  wire  [7:0]  rd_byte = !hit ? 8'h00 : is_stat ? status : route_reg[idx];

  assign pready  = 1'b1;
  assign pslverr = access && !hit;
  assign prdata  = prdata_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ppr_pkg::NREG; i++) begin
        route_reg[i] <= ppr_pkg::RST_ROUTE;
      end
    end else if (wr_en) begin
      route_reg[idx] <= pwdata[7:0] & wmask(idx);
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= '0;
    end else if (psel && !penable) begin
      prdata_reg <= {24'h000000, rd_byte};
    end
  end

  assign event_route    = route_reg[ppr_pkg::IDX_EVENT];
  assign logic_route    = route_reg[ppr_pkg::IDX_LOGIC];
  assign serial_route   = route_reg[ppr_pkg::IDX_SERIAL];
  assign spi_route      = route_reg[ppr_pkg::IDX_SPI];
  assign two_wire_route = route_reg[ppr_pkg::IDX_TWOWIRE];
  assign timer_a_route  = route_reg[ppr_pkg::IDX_TIMER_A];
  assign timer_b_route  = route_reg[ppr_pkg::IDX_TIMER_B];
  assign pwm_route      = route_reg[ppr_pkg::IDX_PWM];
endmodule // ppr_reg_bank

// ==== tb/ppr_pin_route_props.sv ====
// route selector port checker with bind
`timescale 1ns/1ps
module ppr_pin_route_props (
  input wire logic                        clk,
  input wire logic                        rst_n,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic [ppr_pkg::ADDR_W-1:0]  paddr,
  input wire logic [ppr_pkg::DATA_W-1:0]  pwdata,
  input wire logic [ppr_pkg::NSRC-1:0]    periph_val,
  input wire logic [ppr_pkg::NSRC-1:0]    periph_en,
  input wire logic [7:0]                  pin_a_out,
  input wire logic [7:0]                  pin_a_oe_n,
  input wire logic [7:0]                  pin_c_oe_n,
  input wire logic [7:0]                  pin_d_oe_n,
  input wire logic [7:0]                  pin_f_oe_n
);
  logic [7:0] ev_sh;
  logic [7:0] lt_sh;
  logic [7:0] tb_sh;
  logic       wr_go;
  assign wr_go = psel && penable && pwrite && pready;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // shadow copies of the event, logic and timer b route registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ev_sh <= 8'h00;
    else if (wr_go && paddr == 12'h000) ev_sh <= pwdata[7:0];
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lt_sh <= 8'h00;
    else if (wr_go && paddr == 12'h004) lt_sh <= pwdata[7:0];
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tb_sh <= 8'h00;
    else if (wr_go && paddr == 12'h020) tb_sh <= pwdata[7:0];
  end
  AST_EV_A_PIN: assert property (
    $past(periph_en[0]) |-> pin_a_oe_n[$past(ev_sh[0]) ? 7 : 2] == 1'b0)
    else $error("event A pin not driven");
  AST_EV_A_VAL: assert property (
    $past(periph_en[0]) && !$past(ev_sh[0])
      |-> pin_a_out[2] == $past(periph_val[0]))
    else $error("event A value wrong");
  AST_EV_D: assert property (
    $past(periph_en[1]) |-> pin_d_oe_n[$past(ev_sh[3]) ? 7 : 2] == 1'b0)
    else $error("event D pin not driven");
  AST_EV_F: assert property (
    $past(periph_en[2]) |-> pin_f_oe_n[$past(ev_sh[5]) ? 7 : 2] == 1'b0)
    else $error("event F pin not driven");
  AST_LT0: assert property (
    $past(periph_en) == (34'h1 << 3)
      |-> pin_a_oe_n[$past(lt_sh[0]) ? 6 : 3] == 1'b0)
    else $error("table zero pin not driven");
  AST_TB0: assert property (
    $past(periph_en) == (34'h1 << 28) |-> ($past(tb_sh[0]) ?
      pin_f_oe_n[4] : pin_a_oe_n[2]) == 1'b0)
    else $error("timer b zero pin not driven");
  AST_TB1: assert property (
    $past(periph_en) == (34'h1 << 29) |-> ($past(tb_sh[1]) ?
      pin_f_oe_n[5] : pin_a_oe_n[3]) == 1'b0)
    else $error("timer b one pin not driven");
  AST_OFF: assert property (
    $past(periph_en) == 34'h0 |->
      {pin_a_oe_n, pin_c_oe_n, pin_d_oe_n, pin_f_oe_n} == 32'hffffffff)
    else $error("pin driven with no request");
  cover property (wr_go && paddr == 12'h000);
  cover property (periph_en == (34'h1 << 28));
  cover property (psel && penable && pslverr);
endmodule // ppr_pin_route_props

bind ppr_pin_route ppr_pin_route_props u_props (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
  .periph_val(periph_val), .periph_en(periph_en), .pin_a_out(pin_a_out),
  .pin_a_oe_n(pin_a_oe_n), .pin_c_oe_n(pin_c_oe_n),
  .pin_d_oe_n(pin_d_oe_n), .pin_f_oe_n(pin_f_oe_n));

// ==== tb/ppr_pin_route_tb.sv ====
// self-checking bench for the pin route selector
`timescale 1ns/1ps
module ppr_pin_route_tb;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [33:0] periph_val, periph_en;
  logic [7:0]  pa_o, pc_o, pd_o, pf_o, pa_e, pc_e, pd_e, pf_e;
  logic [31:0] all_o, all_e, pin_i;
  logic [19:0] pi;
  int          bad_count, n_checks, cyc, i;
  // table entry: byte address, write data, slot, expected pin (0 none)
  logic [31:0] tv [61] = '{
    32'h000000a2, 32'h000100a7, 32'h000001d2, 32'h000801d7,
    32'h000002f2, 32'h002002f7, 32'h040003a3, 32'h040103a6,
    32'h040004c3, 32'h04020400, 32'h040005d3, 32'h040405d6,
    32'h080006a0, 32'h080106a4, 32'h080206a2, 32'h080306d4,
    32'h080406c1, 32'h08050600, 32'h08060600, 32'h08070600,
    32'h08000ac0, 32'h08080a00, 32'h08100ad6, 32'h08180a00,
    32'h14000ea4, 32'h14010e00, 32'h14020e00, 32'h14030ea0,
    32'h14040ed4, 32'h14050ec0, 32'h14060ec1, 32'h14070e00,
    32'h140611f7, 32'h180012a2, 32'h180112a2, 32'h180212c2,
    32'h180312a0, 32'h180014c2, 32'h18011400, 32'h18021400,
    32'h180314c2, 32'h1c0017a1, 32'h1c011700, 32'h1c0217c1,
    32'h1c0317d1, 32'h1c041700, 32'h1c0517f1, 32'h1c061700,
    32'h1c071700, 32'h20001ca2, 32'h20011cf4, 32'h20001da3,
    32'h20021df5, 32'h240020a6, 32'h24012000, 32'h240220f2,
    32'h24032000, 32'h240420d4, 32'h24052000, 32'h24062000,
    32'h24072000};
  logic [7:0]  msk [8] = '{ppr_pkg::MASK_EVENT, ppr_pkg::MASK_LOGIC,
    ppr_pkg::MASK_SERIAL, ppr_pkg::MASK_SPI, ppr_pkg::MASK_TWOWIRE,
    ppr_pkg::MASK_TIMER_A, ppr_pkg::MASK_TIMER_B, ppr_pkg::MASK_PWM};
  logic [11:0] rg [8] = '{12'h000, 12'h004, 12'h008, 12'h014, 12'h018,
    12'h01c, 12'h020, 12'h024};
  assign all_o = {pf_o, pd_o, pc_o, pa_o};
  assign all_e = {pf_e, pd_e, pc_e, pa_e};

  ppr_pin_route dut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_val(periph_val), .periph_en(periph_en), .periph_in(pi),
    .pin_a_in(pin_i[7:0]), .pin_c_in(pin_i[15:8]),
    .pin_d_in(pin_i[23:16]), .pin_f_in(pin_i[31:24]),
    .pin_a_out(pa_o), .pin_c_out(pc_o),
    .pin_d_out(pd_o), .pin_f_out(pf_o), .pin_a_oe_n(pa_e),
    .pin_c_oe_n(pc_e), .pin_d_oe_n(pd_e), .pin_f_oe_n(pf_e));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic route(input logic [31:0] t);
    logic [31:0] eo;
    logic        v;
    int          pos;
    v = !(t[15:8] >= 8'd18 && t[15:8] <= 8'd21);
    pos = (t[7:4] == 4'hc ? 8 : t[7:4] == 4'hd ? 16 :
           t[7:4] == 4'hf ? 24 : 0) + int'(t[2:0]);
    eo = 32'hffffffff;
    if (t[7:0] != 8'h00) eo[pos] = 1'b0;
    @(posedge clk);
    periph_en <= '0;
    apb(1'b1, {4'h0, t[31:24]}, {24'h0, t[23:16]});
    @(posedge clk);
    periph_en <= 34'h1 << t[15:8];
    periph_val <= {34{v}};
    repeat (3) @(posedge clk);
    #1;
    chk("pin enables", all_e, eo);
    if (t[7:0] != 8'h00) begin
      chk("pin value", {31'h0, all_o[pos]}, {31'h0, v});
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    {rst_n, psel, penable, pwrite, er} = '0;
    paddr = '0;
    pwdata = '0;
    periph_val = '0;
    periph_en = '0;
    pin_i = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (i = 0; i < 12; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk("reset read", rd, 32'h0);
      chk("slave error", {31'h0, er},
          {31'h0, i == 3 || i == 4 || i == 11});
    end
    pin_i <= {8'h00, 8'h04, 8'h06, 8'h5a};
    repeat (4) @(posedge clk);
    #1;
    chk("pin inputs", {12'h0, pi}, {12'h0, 20'h65db2});
    apb(1'b1, 12'h008, 32'h0000001d);
    apb(1'b1, 12'h014, 32'h00000007);
    repeat (3) @(posedge clk);
    #1;
    chk("idle inputs", {12'h0, pi},
        {12'h0, 4'h6, ppr_pkg::IN_IDLE[15:8], 8'hb2});
    apb(1'b0, 12'h028, 32'h0);
    chk("status", rd, 32'h00000007);
    for (i = 0; i < 8; i++) begin
      apb(1'b1, rg[i], 32'hffffffff);
      apb(1'b0, rg[i], 32'h0);
      chk("field mask", rd, {24'h0, msk[i]});
    end
    apb(1'b1, 12'h00c, 32'hffffffff);
    chk("unmapped write", {31'h0, er}, 32'h1);
    for (i = 0; i < 61; i++) route(tv[i]);
    end_sim();
  end
endmodule // ppr_pin_route_tb
